// [hw/gpe_regs.svh]
// register indices, field positions and reset values of the pin block
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH
// register indices; the byte address is four times the index
`define GPE_IDX_DOUT   8'h50
`define GPE_IDX_DIR    8'h51
`define GPE_IDX_LVL    8'h52
`define GPE_IDX_SOE    8'h53
`define GPE_RST_DOUT   8'h00
`define GPE_RST_DIR    8'hff
`define GPE_RST_LVL    8'h00
`define GPE_RST_SOE    8'h00
// bit 1 of the pin registers drives no pin
`define GPE_PIN_MASK   8'hfd
`define GPE_IDX_LSB    2
`define GPE_IDX_MSB    9
`define GPE_HSIZE_WORD 3'h2
`endif

// [hw/gpe_pkg.sv]
// types of the pin direction and stream enable block
package gpe_pkg;
   typedef logic [7:0] gpe_byte_t;
   typedef struct packed {
      gpe_byte_t dout;
      gpe_byte_t dir;
      gpe_byte_t soe;
      gpe_byte_t gpio_out;
      gpe_byte_t gpio_oe;
      gpe_byte_t strm_out;
      gpe_byte_t strm_oe;
   } gpe_core_s;
   typedef struct packed {
      logic        wr_pend;
      logic        hit;
      gpe_byte_t   idx;
      logic        ready;
      logic [31:0] rdata;
   } gpe_ahb_s;
   typedef struct packed {
      gpe_byte_t meta;
      gpe_byte_t level;
   } gpe_sync_s;
endpackage

// [hw/gpe_reg_if.sv]
// register access carrier between the bus slave and the pin core
`timescale 1ns/1ps
interface gpe_reg_if;
   logic               wr_stb;
   logic               hit;
   gpe_pkg::gpe_byte_t idx;
   logic [31:0]        wdata;
   gpe_pkg::gpe_byte_t rdata;
   modport bus  (output wr_stb, hit, idx, wdata, input rdata);
   modport core (input wr_stb, hit, idx, wdata, output rdata);
endinterface

// [hw/gpe_pin_sync.sv]
// two-stage synchroniser for the general-purpose pin levels
`timescale 1ns/1ps
`include "gpe_regs.svh"
module gpe_pin_sync (
   input  logic               clock,
   input  logic               sys_rst,
   input  gpe_pkg::gpe_byte_t pin_async,
   output gpe_pkg::gpe_byte_t pin_level
);
   gpe_pkg::gpe_sync_s sync_reg;
   gpe_pkg::gpe_sync_s sync_next;

   always_comb begin
      sync_next.meta  = pin_async;
      sync_next.level = sync_reg.meta;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_reg <= '{meta: `GPE_RST_LVL, level: `GPE_RST_LVL};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pin_level = sync_reg.level;
endmodule // gpe_pin_sync

// [hw/gpe_ahb_slave.sv]
// ahb-lite slave: writes with no wait, reads with one wait state
`timescale 1ns/1ps
`include "gpe_regs.svh"
module gpe_ahb_slave (
   input  logic        clock,
   input  logic        sys_rst,
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic [31:0] hrdata,
   output logic        hresp,
   gpe_reg_if.bus      regs
);
   gpe_pkg::gpe_ahb_s ahb_reg;
   gpe_pkg::gpe_ahb_s ahb_next;
   logic              take;

   assign take         = hsel && htrans[1] && hready;
   assign regs.wr_stb  = ahb_reg.wr_pend;
   assign regs.hit     = ahb_reg.hit;
   assign regs.idx     = ahb_reg.idx;
   assign regs.wdata   = hwdata;
   assign hreadyout    = ahb_reg.ready;
   assign hrdata       = ahb_reg.rdata;
   assign hresp        = 1'b0;

   always_comb begin
      ahb_next         = ahb_reg;
      ahb_next.wr_pend = 1'b0;
      if (!ahb_reg.ready) begin
         ahb_next.ready = 1'b1;
         ahb_next.rdata = {24'h000000, regs.rdata};
      end
      if (take) begin
         ahb_next.idx     = haddr[`GPE_IDX_MSB:`GPE_IDX_LSB];
         ahb_next.hit     = (haddr[31:10] == 22'h000000) && (hsize == `GPE_HSIZE_WORD);
         ahb_next.wr_pend = hwrite;
         ahb_next.ready   = hwrite;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ahb_reg <= '{wr_pend: 1'b0, hit: 1'b0, idx: 8'h00, ready: 1'b1, rdata: 32'h00000000};
      end else begin
         ahb_reg <= ahb_next;
      end
   end
endmodule // gpe_ahb_slave

// [hw/gpe_top.sv]
// pin direction, pin level and stream output enable block
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gpe_regs.svh"
// ****************************************************************
// Contract
// - direction register at 51h, bits 7..2,0
// - direction 0 drives pin, 1 floats it; a pin with pin_alt_en set follows pin_alt_oe instead
// - direction register resets to ffh
// - bit 1 reserved, controls no pin
// - level register at 52h reads pin levels
// - level register resets 00h, ignores writes
// - stream enable register at 53h, eight bits
// - stream enable 1 drives, 0 disables
// - stream enable register resets to 00h
// - output pin drives data register 50h bit; a pin with pin_alt_en set drives pin_alt_out instead
// ****************************************************************
module gpe_top (
   input  logic        clock,
   input  logic        sys_rst,
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic        hreadyout,
   output logic [31:0] hrdata,
   output logic        hresp,
   input  logic [7:0]  gpio_in,
   output logic [7:0]  gpio_out,
   output logic [7:0]  gpio_oe,
   input  logic [7:0]  pin_alt_en,
   input  logic [7:0]  pin_alt_out,
   input  logic [7:0]  pin_alt_oe,
   input  logic [7:0]  stream_data,
   output logic [7:0]  stream_out,
   output logic [7:0]  stream_oe
);
   // ****************************************************************
   // constants and state
   // ****************************************************************
   localparam gpe_pkg::gpe_byte_t PIN_MASK = `GPE_PIN_MASK;
   localparam gpe_pkg::gpe_core_s CORE_RST = '{
      dout:     `GPE_RST_DOUT,
      dir:      `GPE_RST_DIR,
      soe:      `GPE_RST_SOE,
      gpio_out: 8'h00,
      gpio_oe:  8'h00,
      strm_out: 8'h00,
      strm_oe:  8'h00
   };

   gpe_pkg::gpe_core_s core_reg;
   gpe_pkg::gpe_core_s core_next;
   gpe_pkg::gpe_byte_t pin_level;
   gpe_pkg::gpe_byte_t wdata_b;
   logic               wr_dout;
   logic               wr_dir;
   logic               wr_lvl;
   logic               wr_soe;
   logic               rd_take;

   gpe_reg_if regs ();

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function automatic logic wr_hit(
      input logic               stb,
      input logic               hit,
      input gpe_pkg::gpe_byte_t idx,
      input gpe_pkg::gpe_byte_t want
   );
      return stb && hit && (idx == want);
   endfunction

   function automatic gpe_pkg::gpe_byte_t reg_read(
      input logic               hit,
      input gpe_pkg::gpe_byte_t idx,
      input gpe_pkg::gpe_core_s c,
      input gpe_pkg::gpe_byte_t lvl
   );
      gpe_pkg::gpe_byte_t val;
      val = 8'h00;
      if (hit) begin
         case (idx)
            `GPE_IDX_DOUT: val = c.dout;
            `GPE_IDX_DIR:  val = c.dir;
            `GPE_IDX_LVL:  val = lvl & PIN_MASK;
            `GPE_IDX_SOE:  val = c.soe;
            default:       val = 8'h00;
         endcase
      end
      return val;
   endfunction

   // ****************************************************************
   // bus slave and pin synchroniser
   // ****************************************************************
   gpe_ahb_slave u_ahb (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .regs      (regs.bus)
   );

   gpe_pin_sync u_sync (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .pin_async (gpio_in),
      .pin_level (pin_level)
   );

   // ****************************************************************
   // register access
   // ****************************************************************
   assign wdata_b = regs.wdata[7:0];
   assign wr_dout = wr_hit(regs.wr_stb, regs.hit, regs.idx, `GPE_IDX_DOUT);
   assign wr_dir  = wr_hit(regs.wr_stb, regs.hit, regs.idx, `GPE_IDX_DIR);
   assign wr_lvl  = wr_hit(regs.wr_stb, regs.hit, regs.idx, `GPE_IDX_LVL);
   assign wr_soe  = wr_hit(regs.wr_stb, regs.hit, regs.idx, `GPE_IDX_SOE);
   assign rd_take = hsel && htrans[1] && hready && !hwrite;

   // level register reads the synchronised pins, reserved bit as zero
   assign regs.rdata = reg_read(regs.hit, regs.idx, core_reg, pin_level);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      core_next = core_reg;
      if (wr_dout) begin
         core_next.dout = wdata_b;
      end
      if (wr_dir) begin
         core_next.dir = wdata_b;
      end
      if (wr_soe) begin
         core_next.soe = wdata_b;
      end
      // a write to the level register falls through with no effect
      for (int i = 0; i < 8; i++) begin
         if (pin_alt_en[i]) begin
            core_next.gpio_out[i] = pin_alt_out[i];
            core_next.gpio_oe[i]  = pin_alt_oe[i];
         end else begin
            core_next.gpio_out[i] = PIN_MASK[i] & core_next.dout[i];
            core_next.gpio_oe[i]  = PIN_MASK[i] & ~core_next.dir[i];
         end
      end
      core_next.strm_out = stream_data;
      core_next.strm_oe  = core_next.soe;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         core_reg <= CORE_RST;
      end else begin
         core_reg <= core_next;
      end
   end

   // ****************************************************************
   // pin outputs; a low enable leaves the pin floating
   // ****************************************************************
   assign gpio_out   = core_reg.gpio_out;
   assign gpio_oe    = core_reg.gpio_oe;
   assign stream_out = core_reg.strm_out;
   assign stream_oe  = core_reg.strm_oe;

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_dir_reset;
      @(posedge clock)
         sys_rst |=> (core_reg.dir == `GPE_RST_DIR) && (core_reg.dout == `GPE_RST_DOUT);
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("direction register not ffh after reset");

   property p_dir_write;
      @(posedge clock) disable iff (sys_rst)
         wr_dir |=> core_reg.dir == $past(wdata_b);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write not stored");

   property p_out_enable;
      @(posedge clock) disable iff (sys_rst)
         !$past(sys_rst) |->
            ((gpio_oe ^ (~core_reg.dir & PIN_MASK)) & ~$past(pin_alt_en)) == 8'h00;
   endproperty
   a_out_enable: assert property (p_out_enable)
      else $error("pin enable does not follow direction");

   property p_input_float;
      @(posedge clock) disable iff (sys_rst)
         (core_reg.dir & ~$past(pin_alt_en) & gpio_oe) == 8'h00;
   endproperty
   a_input_float: assert property (p_input_float)
      else $error("input pin is driven");

   property p_resv_bit;
      @(posedge clock) disable iff (sys_rst)
         !$past(pin_alt_en[1]) |-> !gpio_oe[1] && !gpio_out[1];
   endproperty
   a_resv_bit: assert property (p_resv_bit)
      else $error("reserved bit drives a pin");

   property p_level_sample;
      @(posedge clock) disable iff (sys_rst)
         !$past(sys_rst) && !$past(sys_rst, 2) |-> pin_level == $past(gpio_in, 2);
   endproperty
   a_level_sample: assert property (p_level_sample)
      else $error("pin level not two cycles behind pin");

   property p_level_read;
      @(posedge clock) disable iff (sys_rst)
         rd_take && (haddr[`GPE_IDX_MSB:`GPE_IDX_LSB] == `GPE_IDX_LVL)
            && (haddr[31:10] == 22'h000000) && (hsize == `GPE_HSIZE_WORD)
         |=> !hreadyout ##1 hreadyout && (hrdata == {24'h000000, $past(pin_level) & PIN_MASK});
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("level register read wrong");

   property p_level_nowrite;
      @(posedge clock) disable iff (sys_rst)
         wr_lvl |=> $stable(core_reg.dir) && $stable(core_reg.dout) && $stable(core_reg.soe);
   endproperty
   a_level_nowrite: assert property (p_level_nowrite)
      else $error("write to level register changed state");

   property p_level_reset;
      @(posedge clock)
         sys_rst ##1 sys_rst |-> pin_level == `GPE_RST_LVL;
   endproperty
   a_level_reset: assert property (p_level_reset)
      else $error("level register not 00h in reset");

   property p_soe_write;
      @(posedge clock) disable iff (sys_rst)
         wr_soe |=> (core_reg.soe == $past(wdata_b)) && (stream_oe == $past(wdata_b));
   endproperty
   a_soe_write: assert property (p_soe_write)
      else $error("stream enable write not applied");

   property p_stream_drive;
      @(posedge clock) disable iff (sys_rst)
         !$past(sys_rst) |-> (stream_oe == core_reg.soe) && (stream_out == $past(stream_data));
   endproperty
   a_stream_drive: assert property (p_stream_drive)
      else $error("stream pins do not follow enable");

   property p_soe_reset;
      @(posedge clock)
         sys_rst |=> (stream_oe == 8'h00) && (core_reg.soe == `GPE_RST_SOE);
   endproperty
   a_soe_reset: assert property (p_soe_reset)
      else $error("stream pins enabled after reset");

   property p_dout_drive;
      @(posedge clock) disable iff (sys_rst)
         wr_dout |=> ((gpio_out ^ ($past(wdata_b) & PIN_MASK)) & ~$past(pin_alt_en)) == 8'h00;
   endproperty
   a_dout_drive: assert property (p_dout_drive)
      else $error("pin value does not follow data register");

   property p_alt_override;
      @(posedge clock) disable iff (sys_rst)
         !$past(sys_rst) |->
            (((gpio_oe ^ $past(pin_alt_oe)) | (gpio_out ^ $past(pin_alt_out)))
               & $past(pin_alt_en)) == 8'h00;
   endproperty
   a_alt_override: assert property (p_alt_override)
      else $error("alternate function not passed to pin");

   property p_read_wait;
      @(posedge clock) disable iff (sys_rst)
         rd_take |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read did not take exactly one wait state");

   property p_write_nowait;
      @(posedge clock) disable iff (sys_rst)
         hsel && htrans[1] && hready && hwrite |=> hreadyout && regs.wr_stb;
   endproperty
   a_write_nowait: assert property (p_write_nowait)
      else $error("write stalled the bus");

   property p_dir_hold;
      @(posedge clock) disable iff (sys_rst)
         !wr_dir |=> $stable(core_reg.dir);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction register changed without a write");

   property p_soe_hold;
      @(posedge clock) disable iff (sys_rst)
         !wr_soe |=> $stable(core_reg.soe);
   endproperty
   a_soe_hold: assert property (p_soe_hold)
      else $error("stream enable register changed without a write");

   property p_dout_hold;
      @(posedge clock) disable iff (sys_rst)
         !wr_dout |=> $stable(core_reg.dout);
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("data register changed without a write");

   property p_bad_size_write;
      @(posedge clock) disable iff (sys_rst)
         hsel && htrans[1] && hready && hwrite && (hsize != `GPE_HSIZE_WORD)
         |=> ##1 $stable(core_reg.dir) && $stable(core_reg.dout) && $stable(core_reg.soe);
   endproperty
   a_bad_size_write: assert property (p_bad_size_write)
      else $error("write of wrong size changed a register");

   property p_bad_size_read;
      @(posedge clock) disable iff (sys_rst)
         rd_take && (hsize != `GPE_HSIZE_WORD) |=> ##1 hreadyout && (hrdata == 32'h00000000);
   endproperty
   a_bad_size_read: assert property (p_bad_size_read)
      else $error("read of wrong size returned data");

   property p_pins_reset;
      @(posedge clock)
         sys_rst |=> (stream_out == 8'h00) && (gpio_oe == 8'h00) && (gpio_out == 8'h00);
   endproperty
   a_pins_reset: assert property (p_pins_reset)
      else $error("pins driven after reset");

endmodule // gpe_top

// [test/gpe_board.sv]
// board model: drives input pins and watches the stream lines
`timescale 1ns/1ps
module gpe_board (
   input  logic [7:0] gpio_out,
   input  logic [7:0] gpio_oe,
   input  logic [7:0] ext_level,
   input  logic [7:0] stream_out,
   input  logic [7:0] stream_oe,
   output logic [7:0] gpio_in,
   output logic [7:0] stream_pin
);
   logic [7:0] last_strm;
   initial last_strm = 8'h00;
   // the board drives every pin that the device leaves undriven
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
   // a released stream line shows the inverse of its last driven level
   always @(stream_out, stream_oe) last_strm = (stream_oe & stream_out) | (~stream_oe & last_strm);
   assign stream_pin = (stream_oe & stream_out) | (~stream_oe & ~last_strm);
endmodule // gpe_board

// [test/tb_top.sv]
// self-checking bench of the pin direction and stream enable block
`timescale 1ns/1ps
`include "gpe_regs.svh"
module tb_top;
   logic        clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize, sz;
   logic [7:0]  gpio_in, gpio_out, gpio_oe, alt_en, alt_out, alt_oe, ext;
   logic [7:0]  stream_data, stream_out, stream_oe, stream_pin, d, o, s, lvl;
   int          errors, cmp_count;
   assign hready = hreadyout;
   gpe_top DUT (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_alt_en(alt_en), .pin_alt_out(alt_out),
      .pin_alt_oe(alt_oe), .stream_data(stream_data), .stream_out(stream_out),
      .stream_oe(stream_oe));
   gpe_board board (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext),
      .stream_out(stream_out), .stream_oe(stream_oe), .gpio_in(gpio_in),
      .stream_pin(stream_pin));
   // ****************************************************************
   // bus and compare tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("mismatch hready expected 1 seen %b", hready);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      hsize  <= sz;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] dat);
      logic [31:0] x;
      bus(1'b1, idx, dat, x);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk(what, exp, x);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   function automatic logic [7:0] exp_oe(input logic [7:0] dir);
      return (alt_en & alt_oe) | (~alt_en & ~dir & `GPE_PIN_MASK);
   endfunction
   function automatic logic [7:0] exp_out(input logic [7:0] dat);
      return (alt_en & alt_out) | (~alt_en & dat & `GPE_PIN_MASK);
   endfunction
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************************************
   // clock, watchdog and tests
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      summarize();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      {alt_en, alt_out, alt_oe, stream_data, ext} = '0;
      sys_rst = 1'b1;
      errors = 0;
      cmp_count = 0;
      sz = `GPE_HSIZE_WORD;
      r = $urandom(32'hc859);
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk("gpio_oe", 32'h0, {24'h0, gpio_oe});
      chk("stream_oe", 32'h0, {24'h0, stream_oe});
      @(posedge clock);
      rd_chk("dir", `GPE_IDX_DIR, 32'hff);
      rd_chk("soe", `GPE_IDX_SOE, 32'h0);
      rd_chk("unmapped", 8'h60, 32'h0);
      sz = 3'h0;
      wr(`GPE_IDX_SOE, 32'hff);
      rd_chk("dir bad size", `GPE_IDX_DIR, 32'h0);
      sz = `GPE_HSIZE_WORD;
      rd_chk("soe bad size", `GPE_IDX_SOE, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         d = (i == 0) ? 8'h00 : 8'($urandom);
         o = (i == 0) ? 8'hff : 8'($urandom);
         ext <= 8'($urandom);
         alt_en <= (i < 4) ? 8'h00 : 8'($urandom);
         alt_out <= 8'($urandom);
         alt_oe <= 8'($urandom);
         wr(`GPE_IDX_DOUT, {r[23:0], o});
         wr(`GPE_IDX_DIR, {r[31:8], d});
         @(negedge clock);
         chk("gpio_oe", {24'h0, exp_oe(d)}, {24'h0, gpio_oe});
         chk("gpio_out", {24'h0, exp_out(o) & exp_oe(d)}, {24'h0, gpio_out & gpio_oe});
         @(posedge clock);
         rd_chk("dir", `GPE_IDX_DIR, {24'h0, d});
         repeat (3) @(posedge clock);
         lvl = ((exp_oe(d) & exp_out(o)) | (~exp_oe(d) & ext)) & `GPE_PIN_MASK;
         rd_chk("level", `GPE_IDX_LVL, {24'h0, lvl});
         wr(`GPE_IDX_LVL, r);
         rd_chk("level kept", `GPE_IDX_LVL, {24'h0, lvl});
      end
      $display("test direction and level done");
      for (int i = 0; i < 10; i++) begin
         s = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         stream_data <= 8'($urandom);
         wr(`GPE_IDX_SOE, {24'h0, s});
         @(negedge clock);
         chk("stream_oe", {24'h0, s}, {24'h0, stream_oe});
         chk("stream pins", {24'h0, stream_data & s}, {24'h0, stream_pin & s});
         @(posedge clock);
         rd_chk("soe", `GPE_IDX_SOE, {24'h0, s});
      end
      $display("test stream enables done");
      sys_rst <= 1'b1;
      repeat (9) @(posedge clock);
      @(negedge clock);
      chk("stream_oe rst", 32'h0, {24'h0, stream_oe});
      chk("gpio_oe rst", 32'h0, {24'h0, gpio_oe});
      @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd_chk("dir again", `GPE_IDX_DIR, 32'hff);
      rd_chk("soe again", `GPE_IDX_SOE, 32'h0);
      $display("test second reset done");
      summarize();
   end
endmodule // tb_top
